// [alu_exec.sv]
// Execution datapath: pointer add, AND/add with literal or memory, shift
// Assumes decoder presents one request per cycle with its operand already
// read; memory writes are consumed the cycle they are shown
`include "alu_defs.svh"
`default_nettype none

module alu_exec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire alu_pkg::op_req_s req,
  output alu_pkg::mem_wr_s mem_wr_q,
  output logic [`DATA_W-1:0] acc_q,
  output alu_pkg::flags_s flags_q,
  output logic [`PTR_W-1:0] ptr0_q,
  output logic [`PTR_W-1:0] ptr1_q,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [`OFS_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic do_wr;
  logic [31:0] wr_word;
  logic [`OFS_W-1:0] ar_ofs;

  // Merge written bytes over the old register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Address and data captured independently, answer once both held
  always_comb begin
    aw_full_d = aw_full_q;
    awaddr_d = awaddr_q;
    w_full_d = w_full_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr[`OFS_W-1:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (awaddr_q == `OFS_ACC || awaddr_q == `OFS_FLAGS ||
                 awaddr_q == `OFS_PTR0 || awaddr_q == `OFS_PTR1) ?
                `RESP_OKAY : `RESP_SLVERR;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d = !w_full_d && !bvalid_d;
  end

  // Read: one cycle from address taken to data valid
  always_comb begin
    arready_d = s_axi_arready || !s_axi_rvalid; // Idle: take an address
    rvalid_d = s_axi_rvalid;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    ar_ofs = s_axi_araddr[`OFS_W-1:0];
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      case (ar_ofs)
        `OFS_ACC: rdata_d = {24'h00_0000, acc_q};
        `OFS_FLAGS: rdata_d = {29'h0000_0000, flags_q};
        `OFS_PTR0: rdata_d = {16'h0000, ptr0_q};
        `OFS_PTR1: rdata_d = {16'h0000, ptr1_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  logic [`DATA_W-1:0] add_a, add_b, add_sum, res, acc_d;
  logic add_cin, add_cout, add_nib, res_valid;
  logic [`PTR_W-1:0] ptr_sext, ptr_sum, ptr0_d, ptr1_d;
  alu_pkg::flags_s flags_d;
  alu_pkg::mem_wr_s mem_wr_d;

  // One adder serves literal, memory and carry adds
  byte_adder #(.W(`DATA_W)) u_add (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_cout),
    .nib_out(add_nib)
  );

  // Operand steering and pointer sum
  always_comb begin
    add_a = acc_q;
    add_b = (req.op == alu_pkg::op_add_imm_to_acc) ? req.imm : req.operand;
    add_cin = (req.op == alu_pkg::op_add_acc_mem_carry) ?
              flags_q.carry : 1'b0;
    ptr_sext = {{(`PTR_W-`IMM_PTR_W){req.imm[`IMM_PTR_W-1]}},
                req.imm[`IMM_PTR_W-1:0]};
    ptr_sum = (req.ptr_sel ? ptr1_q : ptr0_q) + ptr_sext;
  end

  // Result, flags and destination per operation; bus writes lose to it
  always_comb begin
    acc_d = acc_q;
    flags_d = flags_q;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    res = add_sum;
    res_valid = 1'b1;
    mem_wr_d = '0;
    wr_word = 32'h0000_0000;
    if (do_wr) begin
      case (awaddr_q)
        `OFS_ACC: begin
          wr_word = merge({24'h00_0000, acc_q}, wdata_q, wstrb_q);
          acc_d = wr_word[`DATA_W-1:0];
        end
        `OFS_FLAGS: begin
          wr_word = merge({29'h0000_0000, flags_q}, wdata_q, wstrb_q);
          flags_d = wr_word[2:0];
        end
        `OFS_PTR0: begin
          wr_word = merge({16'h0000, ptr0_q}, wdata_q, wstrb_q);
          ptr0_d = wr_word[`PTR_W-1:0];
        end
        `OFS_PTR1: begin
          wr_word = merge({16'h0000, ptr1_q}, wdata_q, wstrb_q);
          ptr1_d = wr_word[`PTR_W-1:0];
        end
        default: wr_word = 32'h0000_0000;
      endcase
    end
    case (req.op)
      alu_pkg::op_pointer_add_imm: begin
        res_valid = 1'b0;
        if (req.ptr_sel) begin
          ptr1_d = ptr_sum;
        end else begin
          ptr0_d = ptr_sum;
        end
      end
      alu_pkg::op_and_imm_to_acc: res = acc_q & req.imm;
      alu_pkg::op_and_acc_with_mem: res = acc_q & req.operand;
      alu_pkg::op_arith_shift_right: begin
        res = {req.operand[7], req.operand[7:1]};
        flags_d.carry = req.operand[0];
      end
      alu_pkg::op_add_imm_to_acc,
      alu_pkg::op_add_acc_with_mem,
      alu_pkg::op_add_acc_mem_carry: begin
        flags_d.carry = add_cout;
        flags_d.nibble_overflow_bit = add_nib;
      end
      default: res_valid = 1'b0;
    endcase
    if (res_valid) begin
      flags_d.zero = (res == 8'h00);
      if (req.op == alu_pkg::op_and_imm_to_acc ||
          req.op == alu_pkg::op_add_imm_to_acc || !req.dest) begin
        acc_d = res;
      end else begin
        mem_wr_d.en = 1'b1;
        mem_wr_d.addr = req.addr;
        mem_wr_d.data = res;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= `ACC_RST;
      flags_q <= `FLAGS_RST;
      ptr0_q <= `PTR_RST;
      ptr1_q <= `PTR_RST;
      mem_wr_q <= '0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      acc_q <= acc_d;
      flags_q <= flags_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      mem_wr_q <= mem_wr_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_PTR_ADD: assert property (@(posedge aclk) disable iff (!aresetn)
    req.op == alu_pkg::op_pointer_add_imm && !req.ptr_sel |=>
    ptr0_q == 16'($past(ptr0_q) + $past(ptr_sext)) && $stable(acc_q))
    else $error("Pointer add result wrong");
  AST_PTR_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    req.op == alu_pkg::op_pointer_add_imm && req.ptr_sel &&
    ptr1_q == 16'hFFFF && req.imm[5:0] == 6'h01 |=> ptr1_q == 16'h0000)
    else $error("Pointer did not wrap");
  AST_AND_IMM: assert property (@(posedge aclk) disable iff (!aresetn)
    req.op == alu_pkg::op_and_imm_to_acc |=>
    acc_q == ($past(acc_q) & $past(req.imm)) && $stable(flags_q.carry)
    && $stable(flags_q.nibble_overflow_bit))
    else $error("Literal AND wrong");
  AST_ADD_IMM: assert property (@(posedge aclk) disable iff (!aresetn)
    req.op == alu_pkg::op_add_imm_to_acc |=>
    {flags_q.carry, acc_q} == 9'($past(acc_q) + $past(req.imm)))
    else $error("Literal add wrong");
  AST_AND_MEM: assert property (@(posedge aclk) disable iff (!aresetn)
    req.op == alu_pkg::op_and_acc_with_mem && req.dest |=>
    mem_wr_q.data == ($past(acc_q) & $past(req.operand)) &&
    $stable(flags_q.carry))
    else $error("Memory AND wrong");
  AST_DEST: assert property (@(posedge aclk) disable iff (!aresetn)
    req.op == alu_pkg::op_add_acc_with_mem |=>
    mem_wr_q.en == $past(req.dest) &&
    (!mem_wr_q.en || mem_wr_q.addr == $past(req.addr)))
    else $error("Destination routing wrong");
  AST_ASR: assert property (@(posedge aclk) disable iff (!aresetn)
    req.op == alu_pkg::op_arith_shift_right && !req.dest |=>
    acc_q[7] == acc_q[6] && acc_q[7] == $past(req.operand[7]) &&
    flags_q.carry == $past(req.operand[0]))
    else $error("Arithmetic shift wrong");
  AST_ADDC: assert property (@(posedge aclk) disable iff (!aresetn)
    req.op == alu_pkg::op_add_acc_mem_carry && !req.dest |=>
    {flags_q.carry, acc_q} == 9'($past(acc_q) + $past(req.operand) +
    $past(flags_q.carry)))
    else $error("Add with carry wrong");
  AST_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    req.op == alu_pkg::op_add_acc_with_mem && req.dest |=>
    flags_q.zero == (mem_wr_q.data == 8'h00))
    else $error("Zero flag wrong");

endmodule

`default_nettype wire

// [alu_defs.svh]
// Constants for the add, AND and shift datapath: offsets, fields, resets
// Assumes inclusion by bare name ahead of the package and modules
//
// How it works
// - Pointer add sign-extends 6-bit literal, adds to chosen 16-bit pointer
// - Pointer sum wraps modulo 65536 without any error indication
// - AND literal into accumulator; only zero flag changes
// - Add literal to accumulator; carry, nibble overflow and zero change
// - AND accumulator with memory byte; only zero flag changes
// - Add accumulator and memory byte; carry, nibble overflow, zero change
// - Destination bit 0 writes accumulator, 1 writes memory location; literal add and AND always write accumulator
// - Arithmetic right shift: bit 0 to carry, bit 7 kept; carry, zero
// - Add accumulator, memory byte and carry; routed by destination bit
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// Register byte offsets on the control bus
`define OFS_ACC 8'h00
`define OFS_FLAGS 8'h04
`define OFS_PTR0 8'h08
`define OFS_PTR1 8'h0C
`define OFS_W 8

// Flag bit positions in the flags register
`define FLAG_CARRY 0
`define FLAG_NIBBLE 1
`define FLAG_ZERO 2

// Field widths
`define DATA_W 8
`define PTR_W 16
`define ADDR_W 7
`define IMM_PTR_W 6

// Reset values
`define ACC_RST 8'h00
`define PTR_RST 16'h0000
`define FLAGS_RST 3'h0

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [alu_pkg.sv]
// Types shared by the datapath, the decoder model and the bench
// Assumes alu_defs.svh is compiled first
`include "alu_defs.svh"
`default_nettype none

package alu_pkg;

  // Operation codes, Gray ordered
  typedef enum logic [2:0] {
    op_idle = 3'h0,
    op_pointer_add_imm = 3'h1,
    op_and_imm_to_acc = 3'h3,
    op_add_imm_to_acc = 3'h2,
    op_and_acc_with_mem = 3'h6,
    op_add_acc_with_mem = 3'h7,
    op_arith_shift_right = 3'h5,
    op_add_acc_mem_carry = 3'h4
  } op_e;

  // One instruction from the decoder with its memory operand
  typedef struct packed {
    op_e op;
    logic [`DATA_W-1:0] imm;
    logic ptr_sel;
    logic dest;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] operand;
  } op_req_s;

  // Write back into the data register file
  typedef struct packed {
    logic en;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } mem_wr_s;

  // Status flags
  typedef struct packed {
    logic zero;
    logic nibble_overflow_bit;
    logic carry;
  } flags_s;

endpackage

`default_nettype wire

// [byte_adder.sv]
// Byte adder with carry in, carry out of bit 7 and out of bit 3
// Assumes purely combinational use inside the datapath
`include "alu_defs.svh"
`default_nettype none

module byte_adder #(
  parameter int W = `DATA_W
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic cin,
  output logic [W-1:0] sum,
  output logic cout,
  output logic nib_out
);

  logic [4:0] low;

  // Low nibble first for the nibble carry, then full width
  always_comb begin
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    {cout, sum} = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    nib_out = low[4];
  end

endmodule

`default_nettype wire

// [decoder_model.sv]
// Model of the decoder and data register file beside the datapath
// Assumes requests are driven just after a rising edge
`include "alu_defs.svh"
`default_nettype none

module decoder_model (
  input wire logic aclk,
  input wire alu_pkg::op_e op,
  input wire logic [`DATA_W-1:0] imm,
  input wire logic ptr_sel,
  input wire logic dest,
  input wire logic [`ADDR_W-1:0] addr,
  input wire alu_pkg::mem_wr_s mem_wr,
  output alu_pkg::op_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`DATA_W-1:0] mem [128];
  // Known contents so operands are predictable
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 2 + 1);
    end
  end
  // Operand read in the cycle of the request
  assign req = '{op: op, imm: imm, ptr_sel: ptr_sel, dest: dest,
                 addr: addr, operand: mem[addr]};
  // Write back consumed the cycle it is shown
  always @(posedge aclk) begin
    if (mem_wr.en === 1'b1) begin
      mem[mem_wr.addr] <= mem_wr.data;
    end
  end
endmodule

`default_nettype wire

// [arith_logic_add_and_shift_tb.sv]
// Self-checking bench for the add, AND and shift datapath
// Assumes the decoder model and the datapath compiled before it
`include "alu_defs.svh"
`default_nettype none

module arith_logic_add_and_shift_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0;
  alu_pkg::op_e op = alu_pkg::op_idle;
  logic [7:0] imm = 8'h00, acc_q;
  logic ptr_sel = 0, dest = 0;
  logic [6:0] addr = 7'h00;
  alu_pkg::op_req_s req;
  alu_pkg::mem_wr_s mem_wr_q;
  alu_pkg::flags_s flags_q;
  logic [15:0] ptr0_q, ptr1_q;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] e_acc = 8'h00;
  logic [2:0] e_f = 3'h0;
  logic [15:0] e_ptr [2] = '{16'h0000, 16'h0000};
  int n_mismatch = 0, total_checks = 0;

  always #12.5 aclk = ~aclk;

  decoder_model decoder_model_inst (.aclk(aclk), .op(op), .imm(imm),
    .ptr_sel(ptr_sel), .dest(dest), .addr(addr), .mem_wr(mem_wr_q),
    .req(req));
  alu_exec alu_exec_inst (.aclk(aclk), .aresetn(aresetn), .req(req),
    .mem_wr_q(mem_wr_q), .acc_q(acc_q), .flags_q(flags_q),
    .ptr0_q(ptr0_q), .ptr1_q(ptr1_q), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////
  // Counts, comparison and closing report
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus write: address and data offered together, wait for response
  task automatic bw(input logic [31:0] a, d, input logic [1:0] er);
    logic ok;
    ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        chk(32'(bresp), 32'(er));
        bready <= 0;
        ok = 1;
      end
    end
    if (!ok) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // Bus read with expected data and response
  task automatic br(input logic [31:0] a, ed, input logic [1:0] er);
    logic ok;
    ok = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
        rready <= 0;
        ok = 1;
      end
    end
    if (!ok) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One instruction: predict, issue for one edge, compare all outputs
  task automatic do_op(input alu_pkg::op_e o, input logic [7:0] k,
                       input logic s, input logic d, input logic [6:0] a);
    logic [7:0] m, b, r;
    logic [8:0] sm;
    logic [4:0] nb;
    logic ci, w, lit;
    @(posedge aclk);
    op <= o;
    imm <= k;
    ptr_sel <= s;
    dest <= d;
    addr <= a;
    // Operand read once the previous write-back has landed
    @(negedge aclk);
    m = decoder_model_inst.mem[a];
    lit = o == alu_pkg::op_add_imm_to_acc || o == alu_pkg::op_and_imm_to_acc;
    b = lit ? k : m;
    ci = (o == alu_pkg::op_add_acc_mem_carry) ? e_f[0] : 1'b0;
    sm = {1'b0, e_acc} + {1'b0, b} + {8'h00, ci};
    nb = {1'b0, e_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    r = sm[7:0];
    case (o)
      alu_pkg::op_pointer_add_imm:
        e_ptr[s] = e_ptr[s] + {{10{k[5]}}, k[5:0]};
      alu_pkg::op_and_imm_to_acc, alu_pkg::op_and_acc_with_mem: begin
        r = e_acc & b;
        e_f[2] = r == 8'h00;
      end
      alu_pkg::op_arith_shift_right: begin
        r = {m[7], m[7:1]};
        e_f = {r == 8'h00, e_f[1], m[0]};
      end
      default: e_f = {r == 8'h00, nb[4], sm[8]};
    endcase
    w = d && !lit && o != alu_pkg::op_pointer_add_imm;
    if (!w && o != alu_pkg::op_pointer_add_imm) e_acc = r;
    @(posedge aclk);
    op <= alu_pkg::op_idle;
    @(negedge aclk);
    chk(32'(acc_q), 32'(e_acc));
    chk(32'(flags_q), 32'(e_f));
    chk({ptr1_q, ptr0_q}, {e_ptr[1], e_ptr[0]});
    chk(32'(mem_wr_q.en), 32'(w));
    if (w) chk(32'({mem_wr_q.addr, mem_wr_q.data}), 32'({a, r}));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset values and unmapped offset
  task automatic t_regs();
    for (int i = 0; i < 4; i++) br(32'(i * 4), 32'h0000_0000, `RESP_OKAY);
    br(32'h0000_0010, 32'h0000_0000, `RESP_SLVERR);
    bw(32'h0000_0010, 32'h0000_00FF, `RESP_SLVERR);
  endtask

  // Pointer add at both ends of the literal range, wrapping both ways
  task automatic t_pointer();
    bw(32'(`OFS_PTR0), 32'h0000_FFF0, `RESP_OKAY);
    e_ptr[0] = 16'hFFF0;
    do_op(alu_pkg::op_pointer_add_imm, 8'h1F, 0, 1, 7'h00);
    bw(32'(`OFS_PTR1), 32'h0000_0010, `RESP_OKAY);
    e_ptr[1] = 16'h0010;
    do_op(alu_pkg::op_pointer_add_imm, 8'h20, 1, 0, 7'h00);
    br(32'(`OFS_PTR0), 32'h0000_000F, `RESP_OKAY);
    bw(32'(`OFS_PTR1), 32'h0000_FFFF, `RESP_OKAY);
    e_ptr[1] = 16'hFFFF;
    do_op(alu_pkg::op_pointer_add_imm, 8'h01, 1, 0, 7'h00);
  endtask

  // Literal add with all carries, then AND keeping carry flags
  task automatic t_literal();
    bw(32'(`OFS_ACC), 32'h0000_008F, `RESP_OKAY);
    e_acc = 8'h8F;
    do_op(alu_pkg::op_add_imm_to_acc, 8'h71, 0, 1, 7'h00);
    do_op(alu_pkg::op_and_imm_to_acc, 8'hFF, 0, 1, 7'h00);
    bw(32'(`OFS_ACC), 32'h0000_00F3, `RESP_OKAY);
    e_acc = 8'hF3;
    do_op(alu_pkg::op_and_imm_to_acc, 8'h0F, 0, 0, 7'h00);
  endtask

  // Memory operand ops with both destinations
  task automatic t_memory();
    do_op(alu_pkg::op_add_acc_with_mem, 8'h00, 0, 1, 7'h7F);
    do_op(alu_pkg::op_add_acc_mem_carry, 8'h00, 0, 0, 7'h08);
    do_op(alu_pkg::op_add_acc_mem_carry, 8'h00, 0, 1, 7'h7F);
    do_op(alu_pkg::op_and_acc_with_mem, 8'h00, 0, 1, 7'h09);
    do_op(alu_pkg::op_and_acc_with_mem, 8'h00, 0, 0, 7'h22);
    do_op(alu_pkg::op_add_acc_with_mem, 8'h00, 0, 1, 7'h7D);
    do_op(alu_pkg::op_add_acc_with_mem, 8'h00, 0, 0, 7'h01);
  endtask

  // Shift keeps the sign bit; carry takes bit 0
  task automatic t_shift();
    do_op(alu_pkg::op_arith_shift_right, 8'h00, 0, 1, 7'h40);
    do_op(alu_pkg::op_arith_shift_right, 8'h00, 0, 0, 7'h40);
    do_op(alu_pkg::op_arith_shift_right, 8'h00, 0, 0, 7'h00);
    bw(32'(`OFS_FLAGS), 32'h0000_0003, `RESP_OKAY);
    e_f = 3'h3;
    do_op(alu_pkg::op_arith_shift_right, 8'h00, 0, 0, 7'h10);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_pointer();
    t_literal();
    t_memory();
    t_shift();
    stop_test();
  end
endmodule

`default_nettype wire
